// File: core/ecc_pkg.sv
package ecc_pkg;

  // Controller clock
  localparam int CLK_PERIOD_NS = 4;

  // Oscillator stabilisation window after the enable output rises
  localparam longint WAKE_MIN_NS = 125_000_000;
  localparam longint WAKE_MAX_NS = 250_000_000;
  localparam int WAKE_MIN_CYC =
    int'((WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int WAKE_MAX_CYC = int'(WAKE_MAX_NS / CLK_PERIOD_NS);
  localparam int WAKE_CNT_W   = 26;

  // Frequency selector: 0=18.432, 1=36.864, 2=49.152, 3=73.728 MHz
  localparam int         NUM_TAPS    = 4;
  localparam int         SEL_W       = 2;
  localparam logic [1:0] SEL_DEFAULT = 2'h0;
  localparam logic [1:0] SEL_BUS_CAP = 2'h1;

  // Channels of the clock switcher
  localparam int NUM_CH = 2;
  localparam int CH_CPU = 0;
  localparam int CH_BUS = 1;

  // Strap level that selects the external oscillator
  localparam logic STRAP_EXT = 1'b1;

  typedef enum logic [2:0] {
    ECC_RUN     = 3'b001,
    ECC_STANDBY = 3'b010,
    ECC_WARM    = 3'b100
  } ecc_pwr_t;

  typedef struct packed {
    logic rtc_match;
    logic keypad_event;
    logic wake_request;
    logic irq_pending;
  } ecc_wake_t;

  typedef struct packed {
    logic bus;
    logic cpu;
  } ecc_clk_t;

endpackage : ecc_pkg

// File: core/ecc_clock_control.sv
`timescale 1ns/100ps
// Function
// - External strap runs CPU and buses from the pad; PLL taps unused.
// - External mode makes the clock pin an input; PLL mode drives it.
// - With pin select low the shared pin is the oscillator enable.
// - In external mode the pad blocks the clock from the second cycle of standby.
// - External mode with pin select high leaves standby at once on wake.
// - External mode, pin select low: wake raises the enable, then waits 0.125-0.25 s.
// - Only unmasked irq, RTC or keypad, or the wake request pin whatever its mask bit, ends standby.
// - In PLL mode a new selector moves CPU and bus clocks over once both taps are low.
// - The switch happens only while old and new clocks are both low.
// - Selector picks 18.432/36.864/49.152/73.728 MHz, bus capped.
// - Strap sampled at power-on reset release; high selects external.
module ecc_clock_control
  import ecc_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_MIN_CYC
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  input  wire logic                power_on_reset_n,
  input  wire logic                clock_source_strap,
  input  wire logic                enable_pin_function_select,
  input  wire logic [SEL_W-1:0]    cpu_clock_select,
  input  wire logic                standby_req,
  input  wire ecc_wake_t           wake_src,
  input  wire ecc_wake_t           wake_mask,
  input  wire logic [NUM_TAPS-1:0] pll_taps,
  input  wire logic                external_clock_pin_in,
  output logic                     external_clock_pin_out,
  output logic                     external_clock_pin_oe_n,
  output logic                     oscillator_enable_out,
  output ecc_clk_t                 clocks,
  output logic                     ext_mode,
  output logic                     in_standby
);

  ////////////////////////////////////////////////////////////////////////////
  logic por_q;
  logic next_por_q;
  logic next_ext_mode;

  always_comb begin
    next_por_q    = power_on_reset_n;
    next_ext_mode = ext_mode;
    if (power_on_reset_n && !por_q) begin
      next_ext_mode = (clock_source_strap == STRAP_EXT);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_q    <= 1'b0;
      ext_mode <= 1'b0;
    end else if (clk_en) begin
      por_q    <= next_por_q;
      ext_mode <= next_ext_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  ecc_pwr_t                pwr_state;
  ecc_pwr_t                next_pwr_state;
  logic [WAKE_CNT_W-1:0]   wake_cnt;
  logic [WAKE_CNT_W-1:0]   next_wake_cnt;
  logic                    osc_en;
  logic                    next_osc_en;
  logic                    wake_hit;
  localparam logic [WAKE_CNT_W-1:0] WAKE_LAST =
    WAKE_CNT_W'(WAKE_CYCLES - 1);

  assign wake_hit = (|(wake_src & wake_mask)) || wake_src.wake_request;

  always_comb begin
    next_pwr_state = pwr_state;
    next_wake_cnt  = wake_cnt;
    case (pwr_state)
      ECC_RUN: begin
        if (standby_req) begin
          next_pwr_state = ECC_STANDBY;
        end
      end
      ECC_STANDBY: begin
        next_wake_cnt = '0;
        if (wake_hit) begin
          if (ext_mode && !enable_pin_function_select) begin
            next_pwr_state = ECC_WARM;
          end else begin
            next_pwr_state = ECC_RUN;
          end
        end
      end
      ECC_WARM: begin
        if (wake_cnt == WAKE_LAST) begin
          next_pwr_state = ECC_RUN;
        end else begin
          next_wake_cnt = wake_cnt + 1'b1;
        end
      end
      default: begin
        next_pwr_state = ECC_RUN;
        next_wake_cnt  = '0;
      end
    endcase
    // enable drops on the same edge as the clocks stop
    next_osc_en = !(pwr_state == ECC_STANDBY &&
                    next_pwr_state == ECC_STANDBY);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_state <= ECC_RUN;
      wake_cnt  <= '0;
      osc_en    <= 1'b1;
    end else if (clk_en) begin
      pwr_state <= next_pwr_state;
      wake_cnt  <= next_wake_cnt;
      osc_en    <= next_osc_en;
    end
  end

  assign oscillator_enable_out = enable_pin_function_select ?
                                 (pwr_state == ECC_RUN) : osc_en;
  assign in_standby = (pwr_state != ECC_RUN);

  ////////////////////////////////////////////////////////////////////////////
  logic                  clk_run;
  logic                  pad_clk;
  logic [NUM_CH-1:0]     clk_q;
  logic [SEL_W-1:0]      cur_sel [NUM_CH];
  logic [SEL_W-1:0]      want_sel [NUM_CH];

  assign pad_clk = external_clock_pin_in &&
                   !(ext_mode && pwr_state == ECC_STANDBY);
  assign clk_run = (pwr_state == ECC_RUN);

  // bus capped at the 36.864 MHz tap
  assign want_sel[CH_CPU] = cpu_clock_select;
  assign want_sel[CH_BUS] = (cpu_clock_select > SEL_BUS_CAP) ?
                            SEL_BUS_CAP : cpu_clock_select;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_switch
    logic [SEL_W-1:0] next_sel;
    logic             next_clk;

    always_comb begin
      next_sel = cur_sel[ch];
      // swap only while both are low
      if (want_sel[ch] != cur_sel[ch] && !pll_taps[cur_sel[ch]] &&
          !pll_taps[want_sel[ch]]) begin
        next_sel = want_sel[ch];
      end
      // external mode feeds both from the pad
      if (!clk_run) begin
        next_clk = 1'b0;
      end else if (ext_mode) begin
        next_clk = pad_clk;
      end else begin
        next_clk = pll_taps[next_sel];
      end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        cur_sel[ch] <= SEL_DEFAULT;
        clk_q[ch]   <= 1'b0;
      end else if (clk_en) begin
        cur_sel[ch] <= next_sel;
        clk_q[ch]   <= next_clk;
      end
    end
  end

  assign clocks.cpu = clk_q[CH_CPU];
  assign clocks.bus = clk_q[CH_BUS];

  assign external_clock_pin_out  = clk_q[CH_CPU];
  assign external_clock_pin_oe_n = ext_mode;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !clk_en);

  sequence seq_slow_wake;
    ext_mode && !enable_pin_function_select &&
    pwr_state == ECC_STANDBY && wake_hit;
  endsequence

  sequence seq_warm_entry;
    pwr_state == ECC_WARM && oscillator_enable_out && wake_cnt == '0;
  endsequence

  a_strap_capture: assert property (
    power_on_reset_n && !por_q |=> ext_mode == $past(clock_source_strap))
    else $error("strap not captured at power-on release");

  a_pin_direction: assert property (
    external_clock_pin_oe_n == ext_mode)
    else $error("clock pin direction wrong for mode");

  a_ext_same_clk: assert property (
    ext_mode && $past(ext_mode) |-> clocks.cpu == clocks.bus)
    else $error("cpu and bus clocks differ in external mode");

  a_pad_blocked: assert property (
    ext_mode && pwr_state == ECC_STANDBY ##1 pwr_state == ECC_STANDBY
    |-> !clocks.cpu && !clocks.bus)
    else $error("clock passed during standby");

  a_fast_wake: assert property (
    ext_mode && enable_pin_function_select &&
    pwr_state == ECC_STANDBY && wake_hit |=> pwr_state == ECC_RUN)
    else $error("fast wake not immediate");

  a_slow_wake: assert property (
    seq_slow_wake |=> seq_warm_entry ##0 !clocks.cpu)
    else $error("oscillator enable not raised before wait");

  a_warm_bound: assert property (
    pwr_state == ECC_WARM |-> wake_cnt <= WAKE_LAST && !clocks.cpu)
    else $error("stabilisation wait overran or leaked clock");

  a_no_spurious: assert property (
    pwr_state == ECC_STANDBY && !wake_hit |=> pwr_state == ECC_STANDBY)
    else $error("standby left without wake source");

  a_osc_low: assert property (
    !enable_pin_function_select && pwr_state == ECC_STANDBY
    ##1 pwr_state == ECC_STANDBY && !enable_pin_function_select
    |-> !oscillator_enable_out)
    else $error("oscillator enable high in standby");

  // Old tap low before the swap, new tap low as the output takes it
  a_switch_low: assert property (
    !ext_mode && $changed(cur_sel[CH_CPU]) |->
    $past(!pll_taps[cur_sel[CH_CPU]]) && !clocks.cpu)
    else $error("clock switched while a tap was high");

  a_sel_follow: assert property (
    want_sel[CH_CPU] != cur_sel[CH_CPU] &&
    !pll_taps[cur_sel[CH_CPU]] && !pll_taps[want_sel[CH_CPU]]
    |=> cur_sel[CH_CPU] == $past(want_sel[CH_CPU]))
    else $error("selector change delayed");

  a_bus_cap: assert property (
    cur_sel[CH_BUS] <= SEL_BUS_CAP)
    else $error("bus clock above cap");

endmodule : ecc_clock_control

// File: sim/ecc_osc_model.sv
`timescale 1ns/100ps
module ecc_osc_model #(
  // Never on an odd multiple of 2 ns, so the pad never moves on a sampling edge
  parameter realtime HALF_NS = 38.4
) (
  input  wire logic en,
  output logic      pad
);
  // stable from first edge
  // A stopped oscillator rests low, so a pad that leaks shows up as edges
  initial begin
    pad = 1'b0;
    forever begin
      #(HALF_NS);
      pad = en ? ~pad : 1'b0;
    end
  end
endmodule : ecc_osc_model

// File: sim/ecc_clock_control_test.sv
`timescale 1ns/100ps
module ecc_clock_control_test;
  import ecc_pkg::*;
  // Short stand-in for the 0.125 s window
  localparam int W = 16;
  logic       clk, sys_rst, clk_en, por_n, strap, sel_hi, standby_req;
  logic       pin_out, oe_n, osc, ext, stby, pad, cpu_q, osc_mid, mon;
  logic [1:0] csel;
  logic [3:0] taps, taps_s;
  // Set before the first clock edge can count an unknown
  logic [7:0] cnt = 8'h00;
  ecc_wake_t  src, mask;
  ecc_clk_t   clks;
  int         mismatches, cmp_count, run, n;

  ecc_clock_control #(.WAKE_CYCLES(W)) ecc_clock_control_inst (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .power_on_reset_n(por_n), .clock_source_strap(strap),
    .enable_pin_function_select(sel_hi), .cpu_clock_select(csel),
    .standby_req(standby_req), .wake_src(src), .wake_mask(mask),
    .pll_taps(taps), .external_clock_pin_in(pad),
    .external_clock_pin_out(pin_out), .external_clock_pin_oe_n(oe_n),
    .oscillator_enable_out(osc), .clocks(clks), .ext_mode(ext),
    .in_standby(stby));
  ecc_osc_model ecc_osc_model_inst (.en(sel_hi | osc), .pad(pad));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Tap i slower for lower i; shortest half period is two cycles
  assign taps = {cnt[1], cnt[2], cnt[3], cnt[4]};
  always @(negedge clk) cnt <= cnt + 8'h01;
  always @(posedge clk) begin
    taps_s <= taps;
  end
  // A high pulse shorter than the fastest tap is a glitch
  always @(negedge clk) begin
    if (mon && cpu_q === 1'b1 && clks.cpu === 1'b0) begin
      chk_rng("cpu high pulse", run, 2, 999);
    end
    run = (clks.cpu !== cpu_q) ? 1 : run + 1;
    cpu_q = clks.cpu;
  end
  initial begin
    #100_000;
    mismatches++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(string nm, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_rng(string nm, int g, int lo, int hi);
    cmp_count++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  function automatic logic [1:0] bus_sel(logic [1:0] s);
    return (s > SEL_BUS_CAP) ? SEL_BUS_CAP : s;
  endfunction : bus_sel
  task automatic do_reset(logic s);
    sys_rst = 1'b1;
    por_n = 1'b0;
    strap = s;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    por_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask : do_reset
  task automatic enter_standby;
    standby_req = 1'b1;
    @(negedge clk);
    standby_req = 1'b0;
    repeat (20) begin
      @(negedge clk);
      chk_bit("pad blocked", 1'b0, clks.cpu | clks.bus);
    end
  endtask : enter_standby
  task automatic count_wake;
    n = 0;
    while (stby === 1'b1 && n < 4 * W) begin
      @(negedge clk);
      n++;
      if (n == 2) osc_mid = osc;
    end
    src = '0;
  endtask : count_wake
  task automatic results;
    $display("Compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_en = 1'b1;
    sys_rst = 1'b1;
    por_n = 1'b0;
    strap = 1'b0;
    sel_hi = 1'b0;
    csel = SEL_DEFAULT;
    standby_req = 1'b0;
    src = '0;
    mask = '0;
    mon = 1'b0;
    void'($urandom(10));
    do_reset(STRAP_EXT);
    chk_bit("ext mode", 1'b1, ext);
    chk_bit("pin oe_n", 1'b1, oe_n);
    chk_bit("osc enable", 1'b1, osc);
    n = 0;
    repeat (100) begin
      @(negedge clk);
      chk_bit("cpu eq bus", clks.cpu, clks.bus);
      n += int'(clks.cpu);
    end
    chk_rng("pad high", n, 20, 80);
    // Slow wake through the oscillator enable
    enter_standby();
    chk_bit("osc off", 1'b0, osc);
    src = ecc_wake_t'(4'($urandom));
    src.wake_request = 1'b0;
    mask = ecc_wake_t'(~src);
    repeat (10) @(negedge clk);
    chk_bit("masked stays", 1'b1, stby);
    src.wake_request = 1'b1;
    count_wake();
    chk_bit("osc raised", 1'b1, osc_mid);
    chk_rng("slow wake", n, W, 2 * W);
    // Fast wake with the pin as run indicator
    sel_hi = 1'b1;
    enter_standby();
    src.rtc_match = 1'b1;
    mask = '0;
    mask.rtc_match = 1'b1;
    count_wake();
    chk_rng("fast wake", n, 1, 2);
    // PLL mode: every selector code, then random switching
    sel_hi = 1'b0;
    do_reset(~STRAP_EXT);
    chk_bit("ext mode", 1'b0, ext);
    chk_bit("pin oe_n", 1'b0, oe_n);
    mon = 1'b1;
    for (int i = 0; i < 24; i++) begin
      csel = (i < 4) ? 2'(i) : 2'($urandom);
      repeat (40 + $urandom % 30) @(negedge clk);
      chk_bit("cpu clock", taps_s[csel], clks.cpu);
      chk_bit("bus clock", taps_s[bus_sel(csel)], clks.bus);
      chk_bit("pin out", taps_s[csel], pin_out);
    end
    mon = 1'b0;
    results();
  end
endmodule : ecc_clock_control_test
